// >>> chan_ctrl.sv
// channel one control register with its two sub-channels behind a classic wishbone slave
// assumes the timer core supplies counter, direction, match and update strobes on clk_i
`timescale 1ns/1ps
`include "chan_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module chan_ctrl
#(
   parameter int W = 16
)
(
   // clock, reset, enable
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [7:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic [31:0]             dat_o,
   output logic                    ack_o,
   // timer core
   input  wire logic [W-1:0]       cnt_i,
   input  wire logic               count_up_i,
   input  wire logic               center_i,
   input  wire logic               update_i,
   input  wire logic [1:0]         center_irq_dir_a_i,
   input  wire logic               match_a_i,
   input  wire logic               match_b_i,
   // channel pins and brake
   input  wire logic               cap_a_i,
   input  wire logic               cap_b_i,
   input  wire logic               oc_a_i,
   input  wire logic               oc_b_i,
   input  wire logic               brake_i,
   output chan_pkg::pin_drv_t      pin_a_o,
   output chan_pkg::pin_drv_t      pin_b_o,
   // requests
   output logic                    irq_o,
   output logic                    dma_a_o,
   output logic                    dma_b_o
);
   import chan_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave

   bus_state_t  state;
   bus_state_t  next_state;
   logic [13:0] ctrl;
   logic [31:0] rd_data;
   logic        trig_a;
   logic        trig_b;
   logic        irq_a;
   logic        irq_b;
   logic [W-1:0] cc_a;
   logic [W-1:0] cc_b;

   wire req     = cyc_i & stb_i;
   wire take    = req & (state == BUS_IDLE);
   wire commit  = req & we_i & (state == BUS_ACK);
   wire hit_ctl = (adr_i == `OFS_CTRL);
   wire hit_ca  = (adr_i == `OFS_CC_A);
   wire hit_cb  = (adr_i == `OFS_CC_B);
   wire wr_ctl  = commit & hit_ctl;
   // only bits 13:0 are stored; the trigger bits live in their own pulse flops
   localparam logic [31:0] CTRL_INIT = `CTRL_RESET;
   wire [31:0] ctrl_view = {16'h0000, trig_b, trig_a, ctrl};

   // reserved upper bits are never stored, so any value written there is lost
   assign next_state = take ? BUS_ACK : BUS_IDLE;
   assign ack_o      = (state == BUS_ACK);

   always_comb
   begin
      if (hit_ctl)
         rd_data = ctrl_view;
      else if (hit_ca)
         rd_data = {16'h0000, cc_a};
      else if (hit_cb)
         rd_data = {16'h0000, cc_b};
      else
         rd_data = 32'h0000_0000;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state <= BUS_IDLE;
      else if (ce_i)
         state <= next_state;
   end

   // read data is latched when the request is taken; ack follows one cycle later
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o <= 32'h0000_0000;
      else if (ce_i && take)
         dat_o <= rd_data;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl <= CTRL_INIT[13:0];
      else if (ce_i && wr_ctl)
      begin
         if (sel_i[0])
            ctrl[7:0] <= dat_i[7:0];
         if (sel_i[1])
            ctrl[13:8] <= dat_i[13:8];
      end
   end

   soft_trig u_trig_a
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .set_i   (wr_ctl & sel_i[1] & dat_i[`BIT_TRIG_A]),
      .pulse_o (trig_a)
   );

   soft_trig u_trig_b
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .set_i   (wr_ctl & sel_i[1] & dat_i[`BIT_TRIG_B]),
      .pulse_o (trig_b)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sub-channels

   wire sub_cfg_t cfg_a = '{
      dma_en:    ctrl[`BIT_DMA_A],
      irq_en:    ctrl[`BIT_IRQ_A],
      shadow_en: ctrl[`BIT_SHD_A],
      capture:   ctrl[`BIT_ROLE_A],
      sel:       ctrl[`BIT_SEL_A_HI:`BIT_SEL_A_LO],
      dir:       center_irq_dir_a_i};

   wire sub_cfg_t cfg_b = '{
      dma_en:    ctrl[`BIT_DMA_B],
      irq_en:    ctrl[`BIT_IRQ_B],
      shadow_en: ctrl[`BIT_SHD_B],
      capture:   ctrl[`BIT_ROLE_B],
      sel:       ctrl[`BIT_SEL_B_HI:`BIT_SEL_B_LO],
      dir:       ctrl[`BIT_DIR_B_HI:`BIT_DIR_B_LO]};

   wire cnt_evt_t evt_a = '{match: match_a_i, count_up: count_up_i,
                            center: center_i, update: update_i};
   wire cnt_evt_t evt_b = '{match: match_b_i, count_up: count_up_i,
                            center: center_i, update: update_i};
   wire cc_wr_t   wr_a  = '{we: commit & hit_ca, be: sel_i[1:0], data: dat_i[15:0]};
   wire cc_wr_t   wr_b  = '{we: commit & hit_cb, be: sel_i[1:0], data: dat_i[15:0]};

   sub_chan #(.W(W)) u_sub_a
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .cfg_i      (cfg_a),
      .evt_i      (evt_a),
      .trig_i     (trig_a),
      .wr_i       (wr_a),
      .cnt_i      (cnt_i),
      .cap_pin_i  (cap_a_i),
      .brake_i    (brake_i),
      .oc_level_i (oc_a_i),
      .cc_o       (cc_a),
      .irq_o      (irq_a),
      .dma_o      (dma_a_o),
      .pin_o      (pin_a_o)
   );

   sub_chan #(.W(W)) u_sub_b
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .cfg_i      (cfg_b),
      .evt_i      (evt_b),
      .trig_i     (trig_b),
      .wr_i       (wr_b),
      .cnt_i      (cnt_i),
      .cap_pin_i  (cap_b_i),
      .brake_i    (brake_i),
      .oc_level_i (oc_b_i),
      .cc_o       (cc_b),
      .irq_o      (irq_b),
      .dma_o      (dma_b_o),
      .pin_o      (pin_b_o)
   );

   // one shared timer interrupt strobe; status flags live in the timer core
   assign irq_o = (irq_a | irq_b) & ce_i;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      take |=> ack_o)
      else $error("request not answered next cycle");
   a_trig_b_fires: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      wr_ctl && sel_i[1] && dat_i[`BIT_TRIG_B] |=> trig_b ##1 !trig_b)
      else $error("B trigger not fired or not cleared");
   a_trig_a_fires: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      wr_ctl && sel_i[1] && dat_i[`BIT_TRIG_A] |=> trig_a ##1 !trig_a)
      else $error("A trigger not fired or not cleared");
   a_irq_gate_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      irq_b |-> ctrl[`BIT_IRQ_B])
      else $error("B interrupt while disabled");
   a_irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      trig_a && ctrl[`BIT_IRQ_A] |-> irq_a && irq_o)
      else $error("A trigger did not interrupt");
   a_dma_gate_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      dma_b_o |-> ctrl[`BIT_DMA_B])
      else $error("B dma while disabled");
   a_dma_gate_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      trig_a && ctrl[`BIT_DMA_A] |-> dma_a_o)
      else $error("A trigger did not request dma");
   a_trig_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      wr_ctl && dat_i[`BIT_TRIG_A] && !(req && !we_i) |=> ##1 !ctrl_view[`BIT_TRIG_A])
      else $error("trigger bit still reads one");
   a_role_b_cap: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ctrl[`BIT_ROLE_B] && trig_b && !update_i |=> cc_b == $past(cnt_i))
      else $error("B capture role did not capture");
   a_trig_b_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      wr_ctl && sel_i[1] && dat_i[`BIT_TRIG_B] |=> ##1 !ctrl_view[`BIT_TRIG_B])
      else $error("B trigger bit still reads one");
   a_irq_off_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      irq_a |-> ctrl[`BIT_IRQ_A])
      else $error("A interrupt while disabled");
   a_dma_off_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      dma_a_o |-> ctrl[`BIT_DMA_A])
      else $error("A dma while disabled");
   a_irq_on_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      trig_b && ctrl[`BIT_IRQ_B] |-> irq_b && irq_o)
      else $error("B trigger did not interrupt");
   a_dma_on_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      trig_b && ctrl[`BIT_DMA_B] |-> dma_b_o)
      else $error("B trigger did not request dma");
   a_role_a_cap: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ctrl[`BIT_ROLE_A] && trig_a && !update_i |=> cc_a == $past(cnt_i))
      else $error("A capture role did not capture");
   a_cmp_b_idle: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      !ctrl[`BIT_ROLE_B] && trig_b && !wr_b.we && !update_i |=> $stable(cc_b))
      else $error("B compare trigger changed register");
   a_dir_b_up: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      center_i && count_up_i && match_b_i && !ctrl[`BIT_ROLE_B] && ctrl[`BIT_IRQ_B] &&
      ctrl[`BIT_DIR_B_LO] |-> irq_b)
      else $error("B up-count match did not interrupt");
   a_dir_a_down: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      center_i && !count_up_i && match_a_i && !ctrl[`BIT_ROLE_A] && ctrl[`BIT_IRQ_A] &&
      center_irq_dir_a_i[`DIR_DOWN_BIT] |-> irq_a)
      else $error("A down-count match did not interrupt");
   a_cap_pin_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ctrl[`BIT_ROLE_B] |=> !pin_b_o.oe)
      else $error("B capture role drives its pin");
   a_cap_pin_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ctrl[`BIT_ROLE_A] |=> !pin_a_o.oe)
      else $error("A capture role drives its pin");
   a_brake_high_b: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      brake_i && !ctrl[`BIT_ROLE_B] &&
      ctrl[`BIT_SEL_B_HI:`BIT_SEL_B_LO] == `BRK_HIGH |=> pin_b_o.oe && pin_b_o.level)
      else $error("B brake high level wrong");

   c_wb_write: cover property (@(posedge clk_i) disable iff (rst_i) commit && hit_ctl);
   c_trig_cap_a: cover property (@(posedge clk_i) disable iff (rst_i)
      trig_a && ctrl[`BIT_ROLE_A]);
   c_dma_b: cover property (@(posedge clk_i) disable iff (rst_i) dma_b_o);

endmodule

// >>> chan_defs.svh
// offsets, field positions, reset values and encodings of the channel one control block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef CHAN_DEFS_SVH
`define CHAN_DEFS_SVH

`define OFS_CTRL       8'h24
`define OFS_CC_A       8'h3C
`define OFS_CC_B       8'h40

`define CTRL_RESET     32'h0000_3000
`define CC_RESET       16'h0000

`define BIT_TRIG_B     15
`define BIT_TRIG_A     14
`define BIT_DIR_B_HI   13
`define BIT_DIR_B_LO   12
`define BIT_DMA_B      11
`define BIT_DMA_A      10
`define BIT_IRQ_B      9
`define BIT_IRQ_A      8
`define BIT_SHD_B      7
`define BIT_SHD_A      6
`define BIT_ROLE_B     5
`define BIT_ROLE_A     4
`define BIT_SEL_B_HI   3
`define BIT_SEL_B_LO   2
`define BIT_SEL_A_HI   1
`define BIT_SEL_A_LO   0

// brake levels in compare role
`define BRK_HIZ        2'h0
`define BRK_KEEP       2'h1
`define BRK_LOW        2'h2
`define BRK_HIGH       2'h3

// capture edge select bits in capture role (01 rise, 10 fall, 11 both)
`define EDGE_RISE_BIT  0
`define EDGE_FALL_BIT  1

// centre-aligned direction select bits (01 up, 10 down, 11 both)
`define DIR_UP_BIT     0
`define DIR_DOWN_BIT   1

`endif

// >>> chan_pkg.sv
// types shared by the channel one control block and its sub-channels
// assumes nothing of its surroundings
package chan_pkg;

   typedef struct packed {
      logic       dma_en;
      logic       irq_en;
      logic       shadow_en;
      logic       capture;
      logic [1:0] sel;
      logic [1:0] dir;
   } sub_cfg_t;

   typedef struct packed {
      logic match;
      logic count_up;
      logic center;
      logic update;
   } cnt_evt_t;

   typedef struct packed {
      logic        we;
      logic [1:0]  be;
      logic [15:0] data;
   } cc_wr_t;

   typedef struct packed {
      logic level;
      logic oe;
   } pin_drv_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;

endpackage

// >>> soft_trig.sv
// self-clearing software trigger bit
// assumes set_i is a one-cycle write strobe from the register slave
`timescale 1ns/1ps
module soft_trig
(
   // clock, reset, enable
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // control
   input  wire logic set_i,
   // state
   output logic      pulse_o
);
   logic armed;

   // holds exactly one cycle after the write, then drops by itself
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         armed <= 1'b0;
      else if (ce_i)
         armed <= set_i;
   end

   assign pulse_o = armed;

   a_trig_self_clear: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      armed && !set_i |=> !armed)
      else $error("trigger bit did not clear itself");

endmodule

// >>> sub_chan.sv
// one capture/compare sub-channel: event sources, capture/compare register, brake pin
// assumes counter, match and update strobes are synchronous to clk_i
`timescale 1ns/1ps
`include "chan_defs.svh"
module sub_chan
#(
   parameter int W = 16
)
(
   // clock, reset, enable
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   // configuration and strobes
   input  wire chan_pkg::sub_cfg_t cfg_i,
   input  wire chan_pkg::cnt_evt_t evt_i,
   input  wire logic               trig_i,
   input  wire chan_pkg::cc_wr_t   wr_i,
   // timer side
   input  wire logic [W-1:0]       cnt_i,
   input  wire logic               cap_pin_i,
   input  wire logic               brake_i,
   input  wire logic               oc_level_i,
   // results
   output logic [W-1:0]            cc_o,
   output logic                    irq_o,
   output logic                    dma_o,
   output chan_pkg::pin_drv_t      pin_o
);
   import chan_pkg::*;

   logic         cap_prev;
   logic [W-1:0] shadow;
   logic [W-1:0] active;
   wire          rise      = cap_pin_i & ~cap_prev;
   wire          fall      = ~cap_pin_i & cap_prev;
   wire          edge_hit  = cfg_i.capture & ((cfg_i.sel[`EDGE_RISE_BIT] & rise) |
                             (cfg_i.sel[`EDGE_FALL_BIT] & fall));
   wire          dir_ok    = ~evt_i.center |
                             (cfg_i.dir[`DIR_UP_BIT] & evt_i.count_up) |
                             (cfg_i.dir[`DIR_DOWN_BIT] & ~evt_i.count_up);
   wire          match_hit = ~cfg_i.capture & evt_i.match & dir_ok;
   wire          cap_load  = cfg_i.capture & (edge_hit | trig_i);
   wire          buffered  = ~cfg_i.capture & cfg_i.shadow_en;
   wire          any_evt   = match_hit | edge_hit | trig_i;
   wire [W-1:0]  merge_s   = {wr_i.be[1] ? wr_i.data[15:8] : shadow[15:8],
                              wr_i.be[0] ? wr_i.data[7:0]  : shadow[7:0]};
   wire [W-1:0]  merge_a   = {wr_i.be[1] ? wr_i.data[15:8] : active[15:8],
                              wr_i.be[0] ? wr_i.data[7:0]  : active[7:0]};

   assign irq_o = any_evt & cfg_i.irq_en;
   assign dma_o = any_evt & cfg_i.dma_en;
   assign cc_o  = active;

   // a capture in the same cycle as a software write wins: the counter value is kept
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cap_prev <= 1'b0;
         shadow   <= `CC_RESET;
         active   <= `CC_RESET;
      end
      else if (ce_i)
      begin
         cap_prev <= cap_pin_i;
         if (wr_i.we)
            shadow <= merge_s;
         if (cap_load)
            active <= cnt_i;
         else if (wr_i.we && !buffered)
            active <= merge_a;
         else if (evt_i.update && buffered)
            active <= shadow;
      end
   end

   // brake level only matters in the compare role; capture role never drives
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pin_o <= '0;
      else if (ce_i)
      begin
         if (cfg_i.capture)
            pin_o <= '0;
         else if (!brake_i)
            pin_o <= '{level: oc_level_i, oe: 1'b1};
         else if (cfg_i.sel == `BRK_HIZ)
            pin_o <= '{level: 1'b0, oe: 1'b0};
         else if (cfg_i.sel == `BRK_KEEP)
            pin_o <= '{level: oc_level_i, oe: 1'b1};
         else
            pin_o <= '{level: cfg_i.sel == `BRK_HIGH, oe: 1'b1};
      end
   end

   a_cap_takes_count: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      cap_load |=> active == $past(cnt_i))
      else $error("capture did not load counter");
   a_cmp_trig_quiet: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      trig_i && !cfg_i.capture && !wr_i.we && !evt_i.update |=> $stable(active))
      else $error("compare trigger changed register");
   a_shadow_holds: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      buffered && wr_i.we && !evt_i.update |=> $stable(active))
      else $error("buffered write reached active value");
   a_brake_level: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      brake_i && !cfg_i.capture && cfg_i.sel == `BRK_LOW |=> pin_o.oe && !pin_o.level)
      else $error("brake low level wrong");
   a_dir_gate: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      evt_i.center && !cfg_i.dir[`DIR_DOWN_BIT] && !evt_i.count_up |-> !match_hit)
      else $error("down match passed direction gate");

   c_edge_capture: cover property (@(posedge clk_i) disable iff (rst_i) edge_hit);
   c_brake_hiz: cover property (@(posedge clk_i) disable iff (rst_i)
      brake_i && !cfg_i.capture && cfg_i.sel == `BRK_HIZ);

endmodule

// >>> tb_top.sv
// self-checking bench for the channel one control block
// assumes chan_ctrl with W=16 behind a classic wishbone slave answering one cycle after taking
`timescale 1ns/1ps
`include "chan_defs.svh"
module tb_top;
   import chan_pkg::*;

   logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [15:0] cnt_i;
   logic        count_up_i, center_i, update_i, match_a_i, match_b_i;
   logic [1:0]  center_irq_dir_a_i;
   logic        cap_a_i, cap_b_i, oc_a_i, oc_b_i, brake_i;
   logic        irq_o, dma_a_o, dma_b_o;
   pin_drv_t    pin_a_o, pin_b_o, p;
   logic [31:0] seed, v;
   logic [31:0] exp_q[$];
   logic [15:0] ccm[2];
   int          n_errors, comparisons, ni, na, nb;
   logic        b;
   logic [1:0]  sl;

   chan_ctrl #(.W(16)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .cnt_i(cnt_i), .count_up_i(count_up_i), .center_i(center_i),
      .update_i(update_i), .center_irq_dir_a_i(center_irq_dir_a_i), .match_a_i(match_a_i),
      .match_b_i(match_b_i), .cap_a_i(cap_a_i), .cap_b_i(cap_b_i), .oc_a_i(oc_a_i),
      .oc_b_i(oc_b_i), .brake_i(brake_i), .pin_a_o(pin_a_o), .pin_b_o(pin_b_o),
      .irq_o(irq_o), .dma_a_o(dma_a_o), .dma_b_o(dma_b_o));

   ////////////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // upper half stays at its reset value of zero
   function automatic logic [31:0] ctrl_w(input logic ch, input logic trig,
      input logic [1:0] dir, input logic [3:0] en, input logic sh, input logic role,
      input logic [1:0] s);
      logic [31:0] r;
      r = {16'h0000, 2'b00, dir, en, 8'h00};
      r[ch ? `BIT_TRIG_B : `BIT_TRIG_A] = trig;
      r[ch ? `BIT_SHD_B : `BIT_SHD_A] = sh;
      r[ch ? `BIT_ROLE_B : `BIT_ROLE_A] = role;
      if (ch)
         r[3:2] = s;
      else
         r[1:0] = s;
      return r;
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] expv);
      comparisons++;
      if (seen !== expv)
      begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
         n_errors++;
      end
   endtask

   task results();
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // read results are noted here and compared by the monitor when ack shows up
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hF;
      if (!w)
         exp_q.push_back(e);
      // no wait-state count is assumed; only the watchdog ends a hung request
      do
         @(posedge clk_i);
      while (ack_o !== 1'b1);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask

   task count(input int n);
      ni = 0;
      na = 0;
      nb = 0;
      repeat (n)
      begin
         @(posedge clk_i);
         ni += int'(irq_o === 1'b1);
         na += int'(dma_a_o === 1'b1);
         nb += int'(dma_b_o === 1'b1);
      end
   endtask

   always @(posedge clk_i)
   begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
         check(dat_o, exp_q.pop_front());
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (40000) @(posedge clk_i);
      n_errors++;
      results();
   end

   initial
   begin
      {rst_i, ce_i} = 2'b11;
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
      {cnt_i, count_up_i, center_i, update_i, match_a_i, match_b_i} = '0;
      {center_irq_dir_a_i, cap_a_i, cap_b_i, oc_a_i, oc_b_i, brake_i} = '0;
      {n_errors, comparisons} = 0;
      seed = 32'h0000_89A9;
      ccm[0] = 16'h0000;
      ccm[1] = 16'h0000;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // reset values, then an unmapped place that must read zero and ignore writes
      wb(0, `OFS_CTRL, 0, `CTRL_RESET);
      wb(0, `OFS_CC_A, 0, 32'h0);
      wb(0, `OFS_CC_B, 0, 32'h0);
      wb(1, 8'h10, 32'hFFFF_FFFF, 0);
      wb(0, 8'h10, 0, 32'h0);
      wb(0, `OFS_CTRL, 0, `CTRL_RESET);
      // software triggers in both roles against every enable pattern
      for (int i = 0; i < 64; i++)
      begin
         b = i[5];
         cnt_i <= 16'(rnd());
         v = ctrl_w(b, 1'b0, 2'b00, 4'(i), 1'b0, i[4], i[4] ? 2'b11 : 2'b01);
         wb(1, `OFS_CTRL, v, 0);
         wb(1, `OFS_CTRL, v | (32'h1 << (b ? `BIT_TRIG_B : `BIT_TRIG_A)), 0);
         count(3);
         check(32'(ni), 32'(b ? i[1] : i[0]));
         check(32'(na), 32'(!b && i[2]));
         check(32'(nb), 32'(b && i[3]));
         if (i[4])
            ccm[b] = cnt_i;
         wb(0, `OFS_CTRL, 0, v);
         wb(0, b ? `OFS_CC_B : `OFS_CC_A, 0, {16'h0, ccm[b]});
      end
      // capture edges in every edge setting
      for (int i = 0; i < 8; i++)
      begin
         b = i[2];
         sl = 2'(i);
         cnt_i <= 16'(rnd());
         wb(1, `OFS_CTRL, ctrl_w(b, 1'b0, 2'b00, b ? 4'h2 : 4'h1, 1'b0, 1'b1, sl), 0);
         if (b)
            cap_b_i <= 1'b1;
         else
            cap_a_i <= 1'b1;
         count(4);
         check(32'(ni), 32'(sl[0]));
         cap_a_i <= 1'b0;
         cap_b_i <= 1'b0;
         count(4);
         check(32'(ni), 32'(sl[1]));
         if (sl != 2'b00)
            ccm[b] = cnt_i;
         wb(0, b ? `OFS_CC_B : `OFS_CC_A, 0, {16'h0, ccm[b]});
      end
      // match interrupts gated by counting direction in centre-aligned mode
      for (int i = 0; i < 32; i++)
      begin
         b = i[4];
         wb(1, `OFS_CTRL, ctrl_w(b, 1'b0, 2'(i), b ? 4'h2 : 4'h1, 1'b0, 1'b0, 2'b01), 0);
         center_irq_dir_a_i <= 2'(i);
         center_i <= i[3];
         count_up_i <= i[2];
         @(posedge clk_i);
         if (b)
            match_b_i <= 1'b1;
         else
            match_a_i <= 1'b1;
         count(1);
         match_a_i <= 1'b0;
         match_b_i <= 1'b0;
         check(32'(ni), 32'(i[3] ? (i[2] ? i[0] : i[1]) : 1));
      end
      // enable low freezes the block: even an enabled up-count match must not interrupt
      @(posedge clk_i);
      ce_i      <= 1'b0;
      match_b_i <= 1'b1;
      count(2);
      check(32'(ni), 32'h0);
      match_b_i <= 1'b0;
      ce_i      <= 1'b1;
      center_i <= 1'b0;
      // brake levels in compare role
      brake_i <= 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         b = i[2];
         sl = 2'(i);
         oc_a_i <= 1'(rnd());
         oc_b_i <= 1'(rnd());
         wb(1, `OFS_CTRL, ctrl_w(b, 1'b0, 2'b00, 4'h0, 1'b0, 1'b0, sl), 0);
         repeat (3) @(posedge clk_i);
         p = b ? pin_b_o : pin_a_o;
         check(32'(p.oe), 32'(sl != 2'b00));
         if (sl != 2'b00)
            check(32'(p.level), 32'(sl == 2'b01 ? (b ? oc_b_i : oc_a_i) : sl[0]));
      end
      brake_i <= 1'b0;
      // compare writes direct and through the shadow, released by an update
      for (int i = 0; i < 4; i++)
      begin
         b = i[1];
         v = rnd() & 32'h0000_FFFF;
         wb(1, `OFS_CTRL, ctrl_w(b, 1'b0, 2'b00, 4'h0, i[0], 1'b0, 2'b01), 0);
         wb(1, b ? `OFS_CC_B : `OFS_CC_A, v, 0);
         wb(0, b ? `OFS_CC_B : `OFS_CC_A, 0, i[0] ? {16'h0, ccm[b]} : v);
         @(posedge clk_i);
         update_i <= 1'b1;
         @(posedge clk_i);
         update_i <= 1'b0;
         ccm[b] = v[15:0];
         wb(0, b ? `OFS_CC_B : `OFS_CC_A, 0, v);
      end
      repeat (3) @(posedge clk_i);
      check(32'(exp_q.size()), 32'h0);
      results();
   end
endmodule
